// ==== rgpf_framer.sv ====
// interrogator command encoder (gap bursts, 1-of-16 ppm) and tag answer framer
// assumes rx_in is the sliced envelope, synchronous to sys_clk
`timescale 1ns/1ps
`default_nettype none
`include "rgpf_map.svh"
// Summary of operation
// - tag-first mode: carrier steady, listen only
// - command mode: everything sent by gaps
// - open with five-gap burst in 1.575 ms
// - each gap one slot: 175 us, 10 us for ppm symbols at fast speed, field fully off
// - one gap per symbol span
// - gap slot index equals nibble value
// - three-gap time reference before symbols
// - read, write, flag and end commands
// - continuous run repeats request burst, collects replies
// - one ms listen window after answers
// - match code: reference plus twelve bits
// - end command: code 111, address 01010, parity
// - decode tag answers as 70 kHz manchester
// - table-driven crc on sent and received frames
module rgpf_framer
  import rgpf_pkg::*;
#(
  parameter int unsigned FRAME_W         = `RGPF_QR_MAX_BITS,
  parameter int unsigned SLOT_GAP_CYC    = `RGPF_GAP_NS / `RGPF_CLK_NS,
  parameter int unsigned SLOT_NORMAL_CYC = `RGPF_SYM_NORMAL_NS / `RGPF_CLK_NS / `RGPF_SLOTS,
  parameter int unsigned SLOT_FAST_CYC   = `RGPF_SYM_FAST_NS / `RGPF_CLK_NS / `RGPF_SLOTS,
  parameter int unsigned LISTEN_CYC      = `RGPF_LISTEN_NS / `RGPF_CLK_NS,
  parameter int unsigned RUN_WAIT_CYC    = `RGPF_RUN_WAIT_NS / `RGPF_CLK_NS,
  parameter int unsigned RX_BIT_CYC      = 1000000000 / `RGPF_CLK_NS / `RGPF_RX_BIT_HZ
) (
  // clock and reset
  input  wire logic               sys_clk,
  input  wire logic               nrst,
  // mode selection
  input  wire logic               tag_speaks_first_mode,
  input  wire logic               fast_speed,
  input  wire logic               continuous_run,
  // command request
  input  wire logic               cmd_valid,
  input  wire logic [2:0]         cmd_kind,
  input  wire logic [63:0]        cmd_nibbles,
  input  wire logic [4:0]         cmd_count,
  input  wire logic               cmd_add_crc,
  output logic                    cmd_ready,
  // rf modulator
  output logic                    carrier_on,
  output logic                    tx_busy,
  // tag answer path
  input  wire logic               rx_in,
  input  wire logic               rx_ready,
  output logic                    rx_valid,
  output logic [FRAME_W-1:0]      rx_frame,
  output logic [`RGPF_LEN_W-1:0]  rx_len,
  output logic                    frame_drop,
  output logic                    listen_window
);
  localparam int unsigned BURST_SLOTS = `RGPF_BURST_NS / `RGPF_GAP_NS;
  localparam int unsigned BW = FRAME_W + `RGPF_LEN_W;
  localparam logic [11:0] HALF3 = 12'((RX_BIT_CYC * 3) / 4);
  localparam logic [11:0] IDLE2 = 12'(RX_BIT_CYC * 2);

  // nibble-wide crc table, polynomial x16+x12+x5+1
  function automatic logic [15:0] crc_tab(input logic [3:0] i);
    case (i)
      4'h0: crc_tab = 16'h0000;  4'h1: crc_tab = 16'h1021;
      4'h2: crc_tab = 16'h2042;  4'h3: crc_tab = 16'h3063;
      4'h4: crc_tab = 16'h4084;  4'h5: crc_tab = 16'h50A5;
      4'h6: crc_tab = 16'h60C6;  4'h7: crc_tab = 16'h70E7;
      4'h8: crc_tab = 16'h8108;  4'h9: crc_tab = 16'h9129;
      4'hA: crc_tab = 16'hA14A;  4'hB: crc_tab = 16'hB16B;
      4'hC: crc_tab = 16'hC18C;  4'hD: crc_tab = 16'hD1AD;
      4'hE: crc_tab = 16'hE1CE;  default: crc_tab = 16'hF1EF;
    endcase
  endfunction : crc_tab

  // one nibble through the crc, msb first
  function automatic logic [15:0] crc_nib(input logic [15:0] c, input logic [3:0] n);
    crc_nib = {c[11:0], 4'h0} ^ crc_tab(c[15:12] ^ n);
  endfunction : crc_nib

  // even parity over a field
  function automatic logic par(input logic [10:0] v);
    par = ^v;
  endfunction : par

  // reset release through two flops
  logic [1:0] rst_sync_reg;
  logic       rst_n;
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      rst_sync_reg <= 2'b00;
    end else begin
      rst_sync_reg <= {rst_sync_reg[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_reg[1];

  // transmit state
  rgpf_tx_e                tx_state_reg, tx_state_next;
  logic [`RGPF_TMR_W-1:0]  tmr_reg, tmr_next, slot_len_reg, slot_len_next;
  logic [15:0]             pat_reg, pat_next, tcrc_reg, tcrc_next;
  logic [3:0]              slot_reg, slot_next, last_reg, last_next;
  logic [63:0]             nib_reg, nib_next;
  logic [4:0]              left_reg, left_next;
  logic                    crcp_reg, crcp_next, auto_reg, auto_next;
  logic                    carrier_reg, carrier_next, ready_reg, ready_next;
  logic                    take, busy_reg, busy_next;
  logic                    sym_end;

  // next symbol: gap alone in the slot named by the nibble
  always_comb begin
    tx_state_next = tx_state_reg;
    tmr_next      = tmr_reg;
    slot_len_next = slot_len_reg;
    pat_next      = pat_reg;
    tcrc_next     = tcrc_reg;
    slot_next     = slot_reg;
    last_next     = last_reg;
    nib_next      = nib_reg;
    left_next     = left_reg;
    crcp_next     = crcp_reg;
    auto_next     = auto_reg;
    take          = cmd_valid && ready_reg;
    sym_end       = (tmr_reg == slot_len_reg - 1'b1) && (slot_reg == last_reg);
    case (tx_state_reg)
      TX_IDLE: begin
        tmr_next  = '0;
        slot_next = 4'h0;
        if ((take || (continuous_run && !cmd_valid)) && !tag_speaks_first_mode) begin
          tx_state_next = TX_SYM;
          auto_next     = !take;
          tcrc_next     = `RGPF_CRC_INIT;
          crcp_next     = 1'b0;
          left_next     = 5'h0;
          if (!take || cmd_kind == RGPF_CMD_REQ || cmd_kind == RGPF_CMD_BYP) begin
            pat_next      = (take && cmd_kind == RGPF_CMD_BYP) ?
                            `RGPF_BURST_PAT_BYP : `RGPF_BURST_PAT_REQ;
            last_next     = 4'(BURST_SLOTS - 1);
            slot_len_next = `RGPF_TMR_W'(SLOT_GAP_CYC);
          end else begin
            pat_next      = `RGPF_REF_PAT;
            last_next     = 4'(`RGPF_SLOTS - 1);
            slot_len_next = fast_speed ? `RGPF_TMR_W'(SLOT_FAST_CYC) :
                                         `RGPF_TMR_W'(SLOT_NORMAL_CYC);
            if (cmd_kind == RGPF_CMD_MATCH) begin
              nib_next  = {cmd_nibbles[63:53], par(cmd_nibbles[63:53]), 52'h0};
              left_next = 5'd3;
            end else if (cmd_kind == RGPF_CMD_END) begin
              nib_next  = {`RGPF_END_CODE, par({3'h0, `RGPF_END_CODE}), 55'h0};
              left_next = 5'd3;
            end else begin
              nib_next  = cmd_nibbles;
              left_next = cmd_count;
              crcp_next = cmd_add_crc;
            end
          end
        end
      end
      TX_SYM: begin
        tmr_next = tmr_reg + 1'b1;
        if (tmr_reg == slot_len_reg - 1'b1) begin
          tmr_next  = '0;
          slot_next = slot_reg + 4'h1;
        end
        if (sym_end) begin
          slot_next = 4'h0;
          last_next = 4'(`RGPF_SLOTS - 1);
          if (left_reg != 5'h0) begin
            pat_next  = 16'h0001 << nib_reg[63:60];
            nib_next  = {nib_reg[59:0], 4'h0};
            left_next = left_reg - 5'h1;
            if (crcp_reg) begin
              tcrc_next = crc_nib(tcrc_reg, nib_reg[63:60]);
            end
          end else if (crcp_reg) begin
            pat_next  = 16'h0001 << tcrc_reg[15:12];
            nib_next  = {tcrc_reg[11:0], 52'h0};
            left_next = 5'd3;
            crcp_next = 1'b0;
          end else begin
            tx_state_next = auto_reg ? TX_WAIT : TX_IDLE;
          end
        end
      end
      TX_WAIT: begin
        tmr_next = tmr_reg + 1'b1;
        if (tmr_reg == `RGPF_TMR_W'(RUN_WAIT_CYC - 1)) begin
          tx_state_next = TX_IDLE;
        end
      end
      default: begin
        tx_state_next = TX_IDLE;
      end
    endcase
    if (tag_speaks_first_mode) begin
      tx_state_next = TX_IDLE;
    end
    carrier_next = !((tx_state_next == TX_SYM) && pat_next[slot_next]);
    ready_next   = (tx_state_next == TX_IDLE) && !tag_speaks_first_mode;
    busy_next    = !ready_next;
  end

  // transmit registers
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      tx_state_reg <= TX_IDLE;
      tmr_reg      <= '0;
      slot_len_reg <= '0;
      pat_reg      <= 16'h0000;
      tcrc_reg     <= `RGPF_CRC_INIT;
      slot_reg     <= 4'h0;
      last_reg     <= 4'h0;
      nib_reg      <= 64'h0;
      left_reg     <= 5'h0;
      crcp_reg     <= 1'b0;
      auto_reg     <= 1'b0;
      carrier_reg  <= 1'b1;
      ready_reg    <= 1'b0;
      busy_reg     <= 1'b1;
    end else begin
      tx_state_reg <= tx_state_next;
      tmr_reg      <= tmr_next;
      slot_len_reg <= slot_len_next;
      pat_reg      <= pat_next;
      tcrc_reg     <= tcrc_next;
      slot_reg     <= slot_next;
      last_reg     <= last_next;
      nib_reg      <= nib_next;
      left_reg     <= left_next;
      crcp_reg     <= crcp_next;
      auto_reg     <= auto_next;
      carrier_reg  <= carrier_next;
      ready_reg    <= ready_next;
      busy_reg     <= busy_next;
    end
  end

  // receive state
  rgpf_rx_e               rx_state_reg, rx_state_next;
  logic                   prev_reg, prev_next;
  logic [11:0]            bcnt_reg, bcnt_next;
  logic [`RGPF_LEN_W-1:0] nbit_reg, nbit_next;
  logic [FRAME_W-1:0]     sh_reg, sh_next;
  logic [3:0]             rnib_reg, rnib_next;
  logic [15:0]            rcrc_reg, rcrc_next;
  logic [`RGPF_TMR_W-1:0] lw_reg, lw_next;
  logic                   drop_reg, drop_next, lwo_reg, lwo_next;
  logic                   edge_seen, push, room, ok;
  logic [7:0]             pre;

  // manchester slicer: a falling mid-bit edge is a one
  always_comb begin
    rx_state_next = rx_state_reg;
    prev_next     = rx_in;
    bcnt_next     = (bcnt_reg == 12'hFFF) ? bcnt_reg : bcnt_reg + 12'h1;
    nbit_next     = nbit_reg;
    sh_next       = sh_reg;
    rnib_next     = rnib_reg;
    rcrc_next     = rcrc_reg;
    lw_next       = (lw_reg != '0) ? lw_reg - 1'b1 : lw_reg;
    drop_next     = 1'b0;
    push          = 1'b0;
    edge_seen     = (rx_in != prev_reg) && carrier_reg;
    pre           = 8'(sh_reg >> (nbit_reg - `RGPF_PRE_BITS));
    ok            = 1'b0;
    case (rx_state_reg)
      RX_IDLE: begin
        if (edge_seen) begin
          rx_state_next = RX_BITS;
          sh_next       = {{(FRAME_W-1){1'b0}}, prev_reg};
          nbit_next     = `RGPF_LEN_W'(1);
          bcnt_next     = 12'h0;
          rcrc_next     = `RGPF_CRC_INIT;
        end
      end
      RX_BITS: begin
        if (edge_seen && bcnt_reg >= HALF3) begin
          bcnt_next = 12'h0;
          sh_next   = {sh_reg[FRAME_W-2:0], prev_reg};
          rnib_next = {rnib_reg[2:0], prev_reg};
          if (nbit_reg <= `RGPF_LEN_W'(FRAME_W)) begin
            nbit_next = nbit_reg + 1'b1;
          end
          if (nbit_reg >= `RGPF_PRE_BITS && nbit_reg[1:0] == 2'b11) begin
            rcrc_next = crc_nib(rcrc_reg, {rnib_reg[2:0], prev_reg});
          end
        end else if (bcnt_reg >= IDLE2) begin
          rx_state_next = RX_DONE;
        end
      end
      RX_DONE: begin
        ok = ((nbit_reg == `RGPF_PRE_BITS) && (pre == `RGPF_END_ACK)) ||
             ((nbit_reg == `RGPF_RW_BITS) && (pre == `RGPF_PREAMBLE) &&
              (rcrc_reg == 16'h0000)) ||
             ((nbit_reg >= `RGPF_QR_MIN_BITS) && (nbit_reg <= `RGPF_LEN_W'(FRAME_W)) &&
              (pre == `RGPF_PREAMBLE));
        if (!ok) begin
          drop_next     = 1'b1;
          rx_state_next = RX_IDLE;
        end else if (room) begin
          push          = 1'b1;
          lw_next       = `RGPF_TMR_W'(LISTEN_CYC);
          rx_state_next = RX_IDLE;
        end
      end
      default: begin
        rx_state_next = RX_IDLE;
      end
    endcase
    lwo_next = (lw_next != '0);
  end

  // receive registers
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rx_state_reg <= RX_IDLE;
      prev_reg     <= 1'b1; // idle level, no false edge
      bcnt_reg     <= 12'h0;
      nbit_reg     <= '0;
      sh_reg       <= '0;
      rnib_reg     <= 4'h0;
      rcrc_reg     <= `RGPF_CRC_INIT;
      lw_reg       <= '0;
      drop_reg     <= 1'b0;
      lwo_reg      <= 1'b0;
    end else begin
      rx_state_reg <= rx_state_next;
      prev_reg     <= prev_next;
      bcnt_reg     <= bcnt_next;
      nbit_reg     <= nbit_next;
      sh_reg       <= sh_next;
      rnib_reg     <= rnib_next;
      rcrc_reg     <= rcrc_next;
      lw_reg       <= lw_next;
      drop_reg     <= drop_next;
      lwo_reg      <= lwo_next;
    end
  end

  // two-entry answer buffer; head entry drives the outputs
  logic [BW-1:0] e0_reg, e0_next, e1_reg, e1_next;
  logic          v0_reg, v0_next, v1_reg, v1_next;
  always_comb begin
    e0_next = e0_reg;
    e1_next = e1_reg;
    v0_next = v0_reg;
    v1_next = v1_reg;
    room    = !v1_reg;
    if (v0_reg && rx_ready) begin
      e0_next = e1_reg;
      v0_next = v1_reg;
      v1_next = 1'b0;
    end
    if (push) begin
      if (!v0_next) begin
        e0_next = {nbit_reg, sh_reg};
        v0_next = 1'b1;
      end else begin
        e1_next = {nbit_reg, sh_reg};
        v1_next = 1'b1;
      end
    end
  end

  // buffer registers
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      e0_reg <= '0;
      e1_reg <= '0;
      v0_reg <= 1'b0;
      v1_reg <= 1'b0;
    end else begin
      e0_reg <= e0_next;
      e1_reg <= e1_next;
      v0_reg <= v0_next;
      v1_reg <= v1_next;
    end
  end

  // outputs straight from flops
  assign cmd_ready     = ready_reg;
  assign carrier_on    = carrier_reg;
  assign tx_busy       = busy_reg;
  assign rx_valid      = v0_reg;
  assign rx_frame      = e0_reg[FRAME_W-1:0];
  assign rx_len        = e0_reg[BW-1:FRAME_W];
  assign frame_drop    = drop_reg;
  assign listen_window = lwo_reg;
endmodule : rgpf_framer
`default_nettype wire

// ==== rgpf_map.svh ====
// constants for the gap and pulse-position command framer
// assumes inclusion by bare name from the framer module
`ifndef RGPF_MAP_SVH
`define RGPF_MAP_SVH
`define RGPF_CLK_NS        8
`define RGPF_TMR_W         20
`define RGPF_SLOTS         16
`define RGPF_GAP_NS        175000
`define RGPF_BURST_NS      1575000
`define RGPF_SYM_NORMAL_NS 2800000
`define RGPF_SYM_FAST_NS   160000
`define RGPF_BURST_PAT_REQ 16'h0155
`define RGPF_BURST_PAT_BYP 16'h0155
`define RGPF_REF_PAT       16'h8081
`define RGPF_END_CODE      8'hEA
`define RGPF_RX_BIT_HZ     70000
`define RGPF_LISTEN_NS     1000000
`define RGPF_RUN_WAIT_NS   3300000
`define RGPF_CRC_INIT      16'hFFFF
`define RGPF_PREAMBLE      8'hFE
`define RGPF_END_ACK       8'hFE
`define RGPF_PRE_BITS      8'd8
`define RGPF_RW_BITS       8'd64
`define RGPF_QR_MIN_BITS   8'd96
`define RGPF_QR_MAX_BITS   160
`define RGPF_LEN_W         8
`endif

// ==== rgpf_pkg.sv ====
// types shared by the framer: command kinds and state encodings
// assumes nothing beyond a SystemVerilog compiler
package rgpf_pkg;
  typedef enum logic [2:0] {
    RGPF_CMD_REQ   = 3'h0,
    RGPF_CMD_BYP   = 3'h1,
    RGPF_CMD_PPM   = 3'h2,
    RGPF_CMD_MATCH = 3'h3,
    RGPF_CMD_END   = 3'h4
  } rgpf_cmd_e;
  typedef enum logic [2:0] {
    TX_IDLE = 3'b001,
    TX_SYM  = 3'b010,
    TX_WAIT = 3'b100
  } rgpf_tx_e;
  typedef enum logic [2:0] {
    RX_IDLE = 3'b001,
    RX_BITS = 3'b010,
    RX_DONE = 3'b100
  } rgpf_rx_e;
endpackage : rgpf_pkg

// ==== rgpf_framer_asserts.sv ====
// checker: timing relations on the framer's ports
// assumes a bind onto rgpf_framer, one clock, nrst low resets
`timescale 1ns/1ps
`default_nettype none
module rgpf_framer_asserts #(
  parameter int unsigned FRAME_W = 160,
  parameter int unsigned SLOT_N  = 20,
  parameter int unsigned SLOT_F  = 5
) (
  // clock and reset
  input wire logic               sys_clk,
  input wire logic               nrst,
  // modes and command side
  input wire logic               tag_speaks_first_mode,
  input wire logic               fast_speed,
  input wire logic               continuous_run,
  input wire logic               cmd_valid,
  input wire logic               cmd_ready,
  input wire logic               carrier_on,
  // answer side
  input wire logic               rx_ready,
  input wire logic               rx_valid,
  input wire logic [FRAME_W-1:0] rx_frame,
  input wire logic [7:0]         rx_len,
  input wire logic               frame_drop,
  input wire logic               listen_window
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!nrst);
  logic [31:0] gap_reg;
  // length of the running field-off stretch
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) gap_reg <= 32'h0;
    else gap_reg <= carrier_on ? 32'h0 : gap_reg + 32'h1;
  end
  // a taken command opens with a slot-zero gap
  sequence s_take;
    cmd_valid && cmd_ready && !tag_speaks_first_mode;
  endsequence
  sequence s_gap_open;
    !carrier_on && !cmd_ready ##1 !carrier_on;
  endsequence
  property p_take;
    s_take |=> s_gap_open;
  endproperty
  a_take: assert property (p_take) else $error("command did not open with a gap");
  property p_idle_on;
    cmd_ready |-> carrier_on;
  endproperty
  a_idle_on: assert property (p_idle_on) else $error("field off while idle");
  property p_tf_on;
    tag_speaks_first_mode |=> carrier_on;
  endproperty
  a_tf_on: assert property (p_tf_on) else $error("field off in tag-first mode");
  property p_tf_ready;
    tag_speaks_first_mode [*2] |-> !cmd_ready;
  endproperty
  a_tf_ready: assert property (p_tf_ready) else $error("command accepted in tag-first");
  property p_gap_len;
    $rose(carrier_on) && !tag_speaks_first_mode |->
      gap_reg % (fast_speed ? SLOT_F : SLOT_N) == 0;
  endproperty
  a_gap_len: assert property (p_gap_len) else $error("gap not whole slots");
  property p_auto;
    continuous_run && cmd_ready && !cmd_valid && !tag_speaks_first_mode |-> ##[1:3] !cmd_ready;
  endproperty
  a_auto: assert property (p_auto) else $error("no automatic burst");
  property p_hold;
    rx_valid && !rx_ready |=> rx_valid && $stable(rx_frame) && $stable(rx_len);
  endproperty
  a_hold: assert property (p_hold) else $error("answer changed while stalled");
  property p_drop;
    frame_drop |=> !frame_drop;
  endproperty
  a_drop: assert property (p_drop) else $error("drop flag longer than a cycle");
  property p_listen;
    $rose(listen_window) |-> listen_window [*8];
  endproperty
  a_listen: assert property (p_listen) else $error("listen window too short");
  property p_len;
    rx_valid |-> rx_len >= 8'd8 && rx_len <= FRAME_W;
  endproperty
  a_len: assert property (p_len) else $error("answer length out of range");
  c_take: cover property (s_take);
endmodule : rgpf_framer_asserts
bind rgpf_framer rgpf_framer_asserts #(.FRAME_W(FRAME_W), .SLOT_N(SLOT_NORMAL_CYC),
  .SLOT_F(SLOT_FAST_CYC)) rgpf_framer_asserts_inst (.sys_clk, .nrst, .tag_speaks_first_mode,
  .fast_speed, .continuous_run, .cmd_valid, .cmd_ready, .carrier_on, .rx_ready, .rx_valid,
  .rx_frame, .rx_len, .frame_drop, .listen_window);
`default_nettype wire

// ==== rgpf_tag_model.sv ====
// tag model: builds answer frames and sends them manchester coded
// assumes the framer samples rx_in on sys_clk, idle level high
`timescale 1ns/1ps
`default_nettype none
module rgpf_tag_model #(
  parameter int unsigned BIT_CYC = 40
) (
  // clock
  input wire logic sys_clk,
  // sliced envelope towards the framer
  output logic     rx_in
);
  initial rx_in = 1'b1;
  // crc-16 msb first over the n leading bits
  function automatic logic [15:0] crc16(input logic [63:0] d, input int n);
    logic [15:0] c;
    int          i;
    c = 16'hFFFF;
    for (i = 0; i < n; i++) c = {c[14:0], 1'b0} ^ ((c[15] ^ d[63 - i]) ? 16'h1021 : 16'h0000);
    return c;
  endfunction : crc16
  // read, write and bypass answers: preamble, header, data, crc
  function automatic logic [159:0] f_64(input logic [7:0] h, input logic [31:0] d);
    return {96'h0, 8'hFE, h, d, crc16({h, d, 24'h0}, 40)};
  endfunction : f_64
  // quick-read answer with a 32-bit quick-read field
  function automatic logic [159:0] f_qr(input logic [2:0] c, input logic [3:0] p,
    input logic [31:0] id, input logic [31:0] q, input logic [15:0] b);
    return {64'h0, 8'hFE, c, p, 1'b0, id, q, b};
  endfunction : f_qr
  // end-process acknowledge, preamble alone
  function automatic logic [159:0] f_end();
    return {152'h0, 8'hFE};
  endfunction : f_end
  // one frame, first bit v[n-1]; a one falls mid-bit
  task automatic send(input logic [159:0] v, input logic [7:0] n);
    int i;
    for (i = n - 1; i >= 0; i--) begin
      repeat (BIT_CYC / 2) @(posedge sys_clk);
      rx_in <= v[i];
      repeat (BIT_CYC / 2) @(posedge sys_clk);
      rx_in <= ~v[i];
    end
    repeat (BIT_CYC / 2) @(posedge sys_clk);
    rx_in <= 1'b1;
    repeat (3 * BIT_CYC) @(posedge sys_clk);
  endtask : send
endmodule : rgpf_tag_model
`default_nettype wire

// ==== rgpf_framer_tb.sv ====
// self-checking bench for the gap and ppm command framer
// assumes shortened slot, bit, window and wait counts set here
`timescale 1ns/1ps
`default_nettype none
`include "rgpf_map.svh"
`define CHK(a, b, m) begin check_count++; if ((a) !== (b)) begin n_errors++; $display("MISMATCH %0t %s", $time, m); end end
module rgpf_framer_tb;
  import rgpf_pkg::*;
  localparam int unsigned SN = 20;
  localparam int unsigned SF = 5;
  logic         sys_clk = 1'b0;
  logic         nrst = 1'b0;
  logic         tag_speaks_first_mode = 1'b0;
  logic         fast_speed = 1'b0;
  logic         continuous_run = 1'b0;
  logic         cmd_valid = 1'b0;
  logic [2:0]   cmd_kind = 3'h0;
  logic [63:0]  cmd_nibbles = 64'h0;
  logic [4:0]   cmd_count = 5'h0;
  logic         cmd_add_crc = 1'b0;
  logic         rx_ready = 1'b0;
  logic         stall = 1'b0;
  wire logic    cmd_ready, carrier_on, tx_busy, rx_in, rx_valid, frame_drop, listen_window;
  wire logic [159:0] rx_frame;
  wire logic [7:0] rx_len;
  int           n_errors = 0;
  int           check_count = 0;
  int           n_drop = 0;
  int           exp_drop = 0;
  int           i;
  logic [7:0]   exp_len[$];
  logic [159:0] exp_frame[$];
  logic [15:0]  mq[$];
  logic [7:0]   l;
  logic [159:0] f;
  always #4 sys_clk = ~sys_clk;
  rgpf_framer #(.SLOT_GAP_CYC(SN), .SLOT_NORMAL_CYC(SN), .SLOT_FAST_CYC(SF), .LISTEN_CYC(50),
    .RUN_WAIT_CYC(5000), .RX_BIT_CYC(40)) rgpf_framer_inst (.sys_clk, .nrst,
    .tag_speaks_first_mode, .fast_speed, .continuous_run, .cmd_valid, .cmd_kind, .cmd_nibbles,
    .cmd_count, .cmd_add_crc, .cmd_ready, .carrier_on, .tx_busy, .rx_in, .rx_ready, .rx_valid,
    .rx_frame, .rx_len, .frame_drop, .listen_window);
  rgpf_tag_model #(.BIT_CYC(40)) rgpf_tag_model_inst (.sys_clk, .rx_in);
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : end_of_test
  // bounded wait for a level of cmd_ready
  task automatic wait_ready(input logic lvl);
    int k;
    for (k = 0; k < 8000 && cmd_ready !== lvl; k++) @(posedge sys_clk) #1;
    if (cmd_ready !== lvl) begin
      n_errors++;
      $display("MISMATCH %0t ready wait ran out", $time);
      end_of_test();
    end
  endtask : wait_ready
  // one command handshake
  task automatic take(input logic [2:0] k, input logic [63:0] nb, input logic [4:0] n,
    input logic c, input logic fs);
    wait_ready(1'b1);
    @(posedge sys_clk);
    cmd_kind <= k;
    cmd_nibbles <= nb;
    cmd_count <= n;
    cmd_add_crc <= c;
    fast_speed <= fs;
    cmd_valid <= 1'b1;
    @(posedge sys_clk);
    cmd_valid <= 1'b0;
  endtask : take
  // sample the field mid-slot against gap masks, bit j = slot j
  task automatic check_slots(input int ns, input int s);
    int k;
    int j;
    repeat (s / 2) @(posedge sys_clk);
    #1;
    for (k = 0; k < mq.size(); k++) for (j = 0; j < ns; j++) begin
      `CHK(carrier_on, ~mq[k][j], "gap slot")
      `CHK(tx_busy, 1'b1, "busy")
      repeat (s) @(posedge sys_clk);
      #1;
    end
  endtask : check_slots
  // send a command and check every slot of it
  task automatic send_cmd(input logic [2:0] k, input logic [63:0] nb, input logic [4:0] n,
    input logic c, input logic fs);
    logic [63:0] en;
    logic [15:0] cr;
    int          j;
    en = nb;
    if (k == RGPF_CMD_MATCH) en = {nb[63:53], ^nb[63:53], 52'h0};
    if (k == RGPF_CMD_END) en = {3'b111, 5'b01010, 1'b1, 3'b000, 52'h0};
    mq = {(k < 3'h2) ? `RGPF_BURST_PAT_REQ : `RGPF_REF_PAT};
    for (j = 0; k > 3'h1 && j < ((k == RGPF_CMD_PPM) ? n : 3); j++)
      mq.push_back(16'h1 << en[63 - 4 * j -: 4]);
    cr = rgpf_tag_model_inst.crc16(nb, 4 * n);
    for (j = 0; k == RGPF_CMD_PPM && c && j < 4; j++) mq.push_back(16'h1 << cr[15 - 4 * j -: 4]);
    take(k, nb, n, c, fs);
    check_slots((k < 3'h2) ? 9 : 16, (k < 3'h2 || !fs) ? SN : SF);
  endtask : send_cmd
  // note an answer, then let the tag send it
  task automatic answer(input logic [159:0] v, input logic [7:0] n, input logic good);
    if (good) begin
      exp_len.push_back(n);
      exp_frame.push_back(v);
    end
    else exp_drop++;
    rgpf_tag_model_inst.send(v, n);
  endtask : answer
  // bounded wait until every noted answer has left the buffer
  task automatic drain();
    int k;
    for (k = 0; k < 3000 && exp_len.size() != 0; k++) @(posedge sys_clk);
    `CHK(exp_len.size(), 0, "answers lost")
    `CHK(n_drop, exp_drop, "drop count")
    if (exp_len.size() != 0) end_of_test();
  endtask : drain
  // random receiver stalls unless a fill test holds them
  always @(posedge sys_clk) rx_ready <= !stall && ($urandom % 3 != 0);
  // compare the oldest noted answer with each frame taken
  always @(posedge sys_clk) begin
    if (frame_drop === 1'b1) n_drop++;
    if (rx_valid === 1'b1 && rx_ready === 1'b1) begin
      l = exp_len.size() ? exp_len.pop_front() : 8'h0;
      f = exp_frame.size() ? exp_frame.pop_front() : 160'h0;
      `CHK(rx_len, l, "answer length")
      `CHK(rx_frame & ((160'h1 << l) - 160'h1), f, "answer bits")
    end
  end
  // main sequence
  initial begin
    void'($urandom(13));
    @(posedge sys_clk) #1;
    `CHK(carrier_on, 1'b1, "reset field")
    `CHK(cmd_ready, 1'b0, "reset ready")
    @(posedge sys_clk);
    nrst <= 1'b1;
    send_cmd(RGPF_CMD_REQ, 64'h0, 5'h0, 1'b0, 1'b0);
    send_cmd(RGPF_CMD_BYP, 64'h0, 5'h0, 1'b0, 1'b0);
    send_cmd(RGPF_CMD_PPM, 64'h0123456789ABCDEF, 5'h10, 1'b0, 1'b0);
    for (i = 0; i < 3; i++) send_cmd(RGPF_CMD_PPM, {$urandom, $urandom}, 5'($urandom % 12 + 1), 1'b1, 1'b1);
    send_cmd(RGPF_CMD_MATCH, {11'($urandom), 53'h0}, 5'h0, 1'b0, 1'b0);
    send_cmd(RGPF_CMD_END, 64'h0, 5'h0, 1'b0, 1'b0);
    $display("test commands done");
    answer(rgpf_tag_model_inst.f_qr(3'($urandom), 4'($urandom), $urandom, $urandom, 16'($urandom)), 8'd96, 1'b1);
    answer(rgpf_tag_model_inst.f_64(8'h08, $urandom), 8'd64, 1'b1);
    answer(rgpf_tag_model_inst.f_64({5'($urandom), 3'h0}, $urandom), 8'd64, 1'b1);
    answer(rgpf_tag_model_inst.f_64(8'h08, $urandom) ^ 160'h1, 8'd64, 1'b0);
    answer(rgpf_tag_model_inst.f_end() ^ 160'h1, 8'd8, 1'b0);
    stall <= 1'b1;
    answer(rgpf_tag_model_inst.f_end(), 8'd8, 1'b1);
    answer(rgpf_tag_model_inst.f_64(8'h10, $urandom), 8'd64, 1'b1);
    `CHK(rx_valid, 1'b1, "full buffer holds")
    stall <= 1'b0;
    drain();
    $display("test answers done");
    @(posedge sys_clk);
    tag_speaks_first_mode <= 1'b1;
    cmd_valid <= 1'b1;
    repeat (2) @(posedge sys_clk);
    for (i = 0; i < 50; i++) begin
      @(posedge sys_clk) #1;
      `CHK(carrier_on, 1'b1, "tag-first field")
      `CHK(cmd_ready, 1'b0, "tag-first refusal")
    end
    @(posedge sys_clk);
    cmd_valid <= 1'b0;
    answer(rgpf_tag_model_inst.f_end(), 8'd8, 1'b1);
    tag_speaks_first_mode <= 1'b0;
    take(RGPF_CMD_PPM, 64'h0, 5'h10, 1'b0, 1'b0);
    repeat (10) @(posedge sys_clk);
    tag_speaks_first_mode <= 1'b1;
    @(posedge sys_clk) #1;
    `CHK(carrier_on, 1'b1, "abort restores field")
    @(posedge sys_clk);
    tag_speaks_first_mode <= 1'b0;
    drain();
    $display("test tag-first done");
    wait_ready(1'b1);
    @(posedge sys_clk);
    continuous_run <= 1'b1;
    wait_ready(1'b0);
    mq = {`RGPF_BURST_PAT_REQ};
    check_slots(9, SN);
    @(posedge sys_clk);
    continuous_run <= 1'b0;
    answer(rgpf_tag_model_inst.f_end(), 8'd8, 1'b1);
    drain();
    $display("test continuous run done");
    end_of_test();
  end
  // cut a hang short
  initial begin
    repeat (90000) @(posedge sys_clk);
    n_errors++;
    $display("MISMATCH %0t run limit reached", $time);
    end_of_test();
  end
endmodule : rgpf_framer_tb
`default_nettype wire
